// ---- logic/apb_reg_device.sv ----
// device end: register port of the self-test controller
`timescale 1ns/1ps
`default_nettype none

module apb_reg_device
    import apb_link_pkg::*;
(
    input wire logic clk_sys, // system and bus clock
    input wire logic system_reset_low, // system reset, active low
    input wire logic test_clock_gate_override, // test pin, forces gates open
    apb_link_if.device bus, // register bus
    output logic [DATA_W-1:0] control_word, // contents of word 0
    output logic clock_gate_open // architectural gate state
);

    logic rst;
    logic [IDX_W-1:0] word_idx;
    logic idx_in_bank;
    logic idx_is_status;
    logic access_go;
    logic access_done;
    logic access_err;
    logic write_en;
    logic gate_open;
    logic [DATA_W-1:0] read_word;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] bank_word;

    logic [DATA_W-1:0] bank_reg [REG_COUNT];
    logic [DATA_W-1:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic ovr_q1_reg;
    logic ovr_q2_reg;
    logic ovr_q3_reg;
    logic ovr_reg;
    logic gate_reg;
    logic [15:0] write_count_reg;
    logic [7:0] err_count_reg;

    // release in step with the clock so no flop leaves reset mid-cycle
    reset_release rst_gen (
        .clk_sys(clk_sys),
        .reset_low_in(system_reset_low),
        .rst_out(rst)
    );

    // override is a test pin, not from clk_sys logic, so it is filtered
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ovr_q1_reg <= 1'b0;
            ovr_q2_reg <= 1'b0;
            ovr_q3_reg <= 1'b0;
        end
        else
        begin
            ovr_q1_reg <= test_clock_gate_override;
            ovr_q2_reg <= ovr_q1_reg;
            ovr_q3_reg <= ovr_q2_reg;
        end
    end

    // a change counts only once the second and third stages agree
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            ovr_reg <= 1'b0;
        else if (ovr_q2_reg == ovr_q3_reg)
            ovr_reg <= ovr_q3_reg;
    end

    // word decode; pprot is not consulted at all
    assign word_idx = bus.paddr;
    assign idx_in_bank = (word_idx < IDX_W'(REG_COUNT));
    assign idx_is_status = (word_idx == STATUS_IDX);
    // neither protection bit takes part in any decode

    // the access phase is seen on the first enable edge with ready low
    assign access_go = bus.bus_clock_enable & bus.psel & bus.penable & ~pready_reg;
    assign access_done = bus.bus_clock_enable & bus.psel & bus.penable & pready_reg;

    // unmapped words fail; the status word cannot be written
    assign access_err = bus.pwrite ? ~idx_in_bank : ~(idx_in_bank | idx_is_status);
    assign write_en = access_go & bus.pwrite & ~access_err;

    // gate opens for bus activity, or always under test override
    assign gate_open = bus.psel | ovr_reg;

    // words 0..7 are storage; any other word except the status word reads as zero
    assign bank_word = idx_in_bank ? bank_reg[word_idx[2:0]] : REG_RESET;

    // built live, so a read sees the counts as of its access edge
    assign status_word = {write_count_reg,
                          err_count_reg,
                          6'h00,
                          ovr_reg,
                          gate_reg};

    assign read_word = idx_is_status ? status_word : bank_word;

    // byte lanes are written independently under their strobe
    genvar lane;
    genvar word;
    generate
        for (word = 0; word < REG_COUNT; word++)
        begin : g_word
            for (lane = 0; lane < STRB_W; lane++)
            begin : g_lane
                logic lane_we;
                assign lane_we = gate_open & write_en & bus.pstrb[lane]
                                 & (word_idx[2:0] == 3'(word));
                always_ff @(posedge clk_sys or posedge rst)
                begin
                    if (rst)
                        bank_reg[word][8*lane +: 8] <= REG_RESET[8*lane +: 8];
                    else if (lane_we)
                        bank_reg[word][8*lane +: 8] <= bus.pwdata[8*lane +: 8];
                end
            end
        end
    endgenerate

    // one wait state always: the answer is computed, then ready is shown
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            pready_reg <= 1'b0;
        else if (access_go)
            pready_reg <= 1'b1;
        else if (access_done)
            pready_reg <= 1'b0;
    end

    // error travels with ready and clears with it
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            pslverr_reg <= 1'b0;
        else if (access_go)
            pslverr_reg <= access_err;
        else if (access_done)
            pslverr_reg <= 1'b0;
    end

    // read data stays put until the next access so a slow master sees it
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            prdata_reg <= REG_RESET;
        else if (access_go)
            prdata_reg <= (bus.pwrite | access_err) ? REG_RESET : read_word;
    end

    // only writes that landed; refused ones go to the error count
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            write_count_reg <= 16'h0000;
        else if (write_en)
            write_count_reg <= write_count_reg + 16'h0001;
    end

    // saturates so a stuck master cannot wrap the count back to zero
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            err_count_reg <= 8'h00;
        else if (access_go & access_err & (err_count_reg != 8'hff))
            err_count_reg <= err_count_reg + 8'h01;
    end

    // registered so the gate output comes from a flop; lags one cycle
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            gate_reg <= 1'b0;
        else
            gate_reg <= gate_open;
    end

    // every bus output is a flop, so the master sees settled values
    assign bus.prdata = prdata_reg;
    assign bus.pready = pready_reg;
    assign bus.pslverr = pslverr_reg;
    assign control_word = bank_reg[0];
    assign clock_gate_open = gate_reg;

endmodule : apb_reg_device

`default_nettype wire

// ---- pkg/apb_link_pkg.sv ----
// shared constants for the register port and its bus master
package apb_link_pkg;

    localparam int ADDR_HI = 11;
    localparam int ADDR_LO = 2;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam int PROT_W = 3;
    localparam int PROT_SECURE_BIT = 1;
    localparam int PROT_INSTR_BIT = 2;
    localparam int IDX_W = ADDR_HI - ADDR_LO + 1;

    // word indices of the register bank
    localparam int REG_COUNT = 8;
    localparam logic [IDX_W-1:0] STATUS_IDX = 10'h008;

    // status word field positions
    localparam int ST_GATE_BIT = 0;
    localparam int ST_OVR_BIT = 1;
    localparam int ST_ERRCNT_LO = 8;
    localparam int ST_WRCNT_LO = 16;

    localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;

    // interconnect runs at clk_sys divided by this; 1 means same rate
    localparam int BUS_CLK_DIV = 2;
    localparam int DIV_W = 4;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BUS_CLK_DIV - 1);
    localparam logic CLKEN_RESET = (BUS_CLK_DIV == 1);

endpackage : apb_link_pkg

// ---- pkg/apb_link_if.sv ----
// register bus between the interconnect master and the device port
`timescale 1ns/1ps
`default_nettype none

interface apb_link_if;
    import apb_link_pkg::*;

    logic bus_clock_enable;
    logic [ADDR_HI:ADDR_LO] paddr;
    logic [PROT_W-1:0] pprot;
    logic psel;
    logic penable;
    logic pwrite;
    logic [DATA_W-1:0] pwdata;
    logic [STRB_W-1:0] pstrb;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;

    modport device (
        input bus_clock_enable, paddr, pprot, psel, penable, pwrite, pwdata, pstrb,
        output prdata, pready, pslverr
    );

    modport master (
        output bus_clock_enable, paddr, pprot, psel, penable, pwrite, pwdata, pstrb,
        input prdata, pready, pslverr
    );

endinterface : apb_link_if

`default_nettype wire

// ---- logic/reset_release.sv ----
// reset stretcher: asserts at once, releases on a clock edge
`timescale 1ns/1ps
`default_nettype none

module reset_release (
    input wire logic clk_sys, // system clock
    input wire logic reset_low_in, // raw active-low reset
    output logic rst_out // active-high reset, clean release
);

    logic stage1_reg;
    logic stage2_reg;

    always_ff @(posedge clk_sys or negedge reset_low_in)
    begin
        if (!reset_low_in)
        begin
            stage1_reg <= 1'b1;
            stage2_reg <= 1'b1;
        end
        else
        begin
            stage1_reg <= 1'b0;
            stage2_reg <= stage1_reg;
        end
    end

    assign rst_out = stage2_reg;

endmodule : reset_release

`default_nettype wire

// ---- logic/apb_bus_master.sv ----
// interconnect end: turns simple requests into register bus transfers
`timescale 1ns/1ps
`default_nettype none

module apb_bus_master
    import apb_link_pkg::*;
(
    input wire logic clk_sys, // system clock
    input wire logic rst, // asynchronous reset, active high
    apb_link_if.master bus, // register bus
    input wire logic req_valid, // request offered
    input wire logic req_write, // 1 write, 0 read
    input wire logic [IDX_W-1:0] req_index, // word index
    input wire logic [DATA_W-1:0] req_wdata, // write data
    input wire logic [STRB_W-1:0] req_strb, // byte strobes
    input wire logic req_secure, // security of this access
    output logic req_ready, // request taken when high with valid
    output logic resp_valid, // one-cycle answer pulse
    output logic [DATA_W-1:0] resp_rdata, // read data
    output logic resp_err // failed transfer
);

    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_ACCESS} phase_type;

    phase_type phase_reg;
    phase_type phase_next;
    logic [DIV_W-1:0] div_reg;
    logic clken_reg;
    logic pending_reg;
    logic write_reg;
    logic [IDX_W-1:0] index_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic [STRB_W-1:0] strb_reg;
    logic prot_reg;
    logic take;
    logic finish;
    logic [DATA_W-1:0] rdata_reg;
    logic err_reg;
    logic resp_reg;

    // divider; with a divide of one the enable never drops
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            div_reg <= '0;
            clken_reg <= CLKEN_RESET;
        end
        else
        begin
            div_reg <= (div_reg == DIV_LAST) ? '0 : div_reg + DIV_W'(1);
            clken_reg <= (div_reg == DIV_LAST) | CLKEN_RESET;
        end
    end

    assign take = req_valid & ~pending_reg;
    assign finish = clken_reg & (phase_reg == ST_ACCESS) & bus.pready;

    always_comb
    begin
        phase_next = phase_reg;
        case (phase_reg)
            ST_IDLE:   if (clken_reg & pending_reg) phase_next = ST_SETUP;
            ST_SETUP:  if (clken_reg) phase_next = ST_ACCESS;
            ST_ACCESS: if (finish) phase_next = ST_IDLE;
            default:   phase_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            phase_reg <= ST_IDLE;
        else
            phase_reg <= phase_next;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pending_reg <= 1'b0;
            write_reg <= 1'b0;
            index_reg <= '0;
            wdata_reg <= '0;
            strb_reg <= '0;
            prot_reg <= 1'b0;
        end
        else if (take)
        begin
            pending_reg <= 1'b1;
            write_reg <= req_write;
            index_reg <= req_index;
            wdata_reg <= req_write ? req_wdata : '0;
            strb_reg <= req_write ? req_strb : '0;
            prot_reg <= req_secure;
        end
        else if (finish)
            pending_reg <= 1'b0;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            resp_reg <= 1'b0;
            rdata_reg <= '0;
            err_reg <= 1'b0;
        end
        else
        begin
            resp_reg <= finish;
            if (finish)
            begin
                rdata_reg <= bus.prdata;
                err_reg <= bus.pslverr;
            end
        end
    end

    assign bus.bus_clock_enable = clken_reg;
    assign bus.paddr = index_reg;
    assign bus.pprot = {1'b0, prot_reg, 1'b0};
    assign bus.psel = (phase_reg != ST_IDLE);
    assign bus.penable = (phase_reg == ST_ACCESS);
    assign bus.pwrite = write_reg;
    assign bus.pwdata = wdata_reg;
    assign bus.pstrb = strb_reg;
    assign req_ready = ~pending_reg;
    assign resp_valid = resp_reg;
    assign resp_rdata = rdata_reg;
    assign resp_err = err_reg;

endmodule : apb_bus_master

`default_nettype wire

// ---- tb/apb_link_monitor.sv ----
// protocol checker for the register link between master and device
`timescale 1ns/1ps
`default_nettype none

module apb_link_monitor
    import apb_link_pkg::*;
(
    input wire logic clk_sys, // clock
    input wire logic rst, // reset, active high
    input wire logic bus_clock_enable, // bus enable
    input wire logic [ADDR_HI:ADDR_LO] paddr, // address
    input wire logic [PROT_W-1:0] pprot, // protection
    input wire logic psel, // select
    input wire logic penable, // enable
    input wire logic pwrite, // direction
    input wire logic [DATA_W-1:0] pwdata, // write data
    input wire logic [STRB_W-1:0] pstrb, // strobes
    input wire logic [DATA_W-1:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr // error
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence s_taken;
        bus_clock_enable && psel && penable && !pready;
    endsequence
    sequence s_answer;
        pready && psel && penable;
    endsequence
    sequence s_held;
        psel && !(pready && bus_clock_enable);
    endsequence
    sequence s_steady;
        psel && $stable(paddr) && $stable(pwrite) && $stable(pwdata) && $stable(pstrb)
            && $stable(pprot);
    endsequence

    AST_ONE_WAIT: assert property (s_taken |=> s_answer)
        else $error("ready did not follow an accepted access");
    AST_READY_QUAL: assert property (pready |-> psel && penable)
        else $error("ready outside an access phase");
    AST_READY_HOLD: assert property (pready && !bus_clock_enable |=> pready && $stable(pslverr))
        else $error("answer dropped between enabled edges");
    AST_READY_CLEAR: assert property (pready && bus_clock_enable |=> !pready && !pslverr)
        else $error("answer held past the completing edge");
    AST_ERR_QUAL: assert property (pslverr |-> pready)
        else $error("error flagged outside a completing cycle");
    AST_STRB_READ: assert property (psel && !pwrite |-> pstrb == 4'h0)
        else $error("strobes set during a read");
    AST_SETUP_FIRST: assert property ($rose(penable) |-> psel && $past(psel))
        else $error("enable rose without a setup cycle");
    AST_HOLD: assert property (s_held |=> s_steady)
        else $error("transfer changed before completion");
    AST_RDATA_STANDS: assert property ($changed(prdata) |-> $past(psel && penable))
        else $error("read data changed outside an access");
    AST_ENABLE_RATE: assert property (bus_clock_enable |=> !bus_clock_enable ##1 bus_clock_enable)
        else $error("bus enable not one edge in two");

endmodule : apb_link_monitor

`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench: bus master and register device joined over the link
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import apb_link_pkg::*;

    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic override = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [IDX_W-1:0] req_index = 10'h000;
    logic [DATA_W-1:0] req_wdata = 32'h0;
    logic [STRB_W-1:0] req_strb = 4'h0;
    logic req_secure = 1'b0;
    logic req_ready, resp_valid, resp_err, gate_open, got_err;
    logic [DATA_W-1:0] resp_rdata, control_word, got;
    logic [IDX_W-1:0] bad_idx [4] = '{10'h008, 10'h009, 10'h3ff, 10'h3ff};
    logic bad_wr [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    int error_cnt = 0;
    int cmp_count = 0;

    apb_link_if link ();

    always #2 clk_sys = ~clk_sys;

    apb_reg_device u_apb_reg_device (.clk_sys(clk_sys), .system_reset_low(~rst),
        .test_clock_gate_override(override), .bus(link.device),
        .control_word(control_word), .clock_gate_open(gate_open));

    apb_bus_master u_apb_bus_master (.clk_sys(clk_sys), .rst(rst), .bus(link.master),
        .req_valid(req_valid), .req_write(req_write), .req_index(req_index),
        .req_wdata(req_wdata), .req_strb(req_strb), .req_secure(req_secure),
        .req_ready(req_ready), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
        .resp_err(resp_err));

    apb_link_monitor u_apb_link_monitor (.clk_sys(clk_sys), .rst(rst),
        .bus_clock_enable(link.bus_clock_enable), .paddr(link.paddr), .pprot(link.pprot),
        .psel(link.psel), .penable(link.penable), .pwrite(link.pwrite),
        .pwdata(link.pwdata), .pstrb(link.pstrb), .prdata(link.prdata),
        .pready(link.pready), .pslverr(link.pslverr));

    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // entered and left on a falling edge; one request outstanding at a time
    task automatic xfer(input logic wr, input logic [IDX_W-1:0] idx,
        input logic [DATA_W-1:0] wd, input logic [STRB_W-1:0] sb);
        int n;
        for (n = 0; n < 64 && req_ready !== 1'b1; n++) @(negedge clk_sys);
        req_valid = 1'b1;
        req_write = wr;
        req_index = idx;
        req_wdata = wd;
        req_strb = sb;
        req_secure = idx[0];
        @(negedge clk_sys);
        req_valid = 1'b0;
        for (n = 0; n < 64 && link.psel !== 1'b1; n++) @(negedge clk_sys);
        check({29'h0, link.pprot}, {29'h0, 1'b0, idx[0], 1'b0});
        for (n = 0; n < 64 && resp_valid !== 1'b1; n++) @(negedge clk_sys);
        check({31'h0, resp_valid}, 32'h1);
        got = resp_rdata;
        got_err = resp_err;
    endtask : xfer

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude

    initial
    begin
        #20000;
        error_cnt++;
        conclude();
    end

    initial
    begin
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        repeat (6) @(negedge clk_sys);
        for (int i = 0; i < REG_COUNT; i++)
        begin
            xfer(1'b1, IDX_W'(i), 32'h5a00_0000 | 32'(i), 4'hf);
            check({31'h0, got_err}, 32'h0);
        end
        for (int i = 0; i < REG_COUNT; i++)
        begin
            xfer(1'b0, IDX_W'(i), 32'h0, 4'h0);
            check(got, 32'h5a00_0000 | 32'(i));
        end
        check(control_word, 32'h5a00_0000);
        xfer(1'b1, 10'h001, 32'haabb_ccdd, 4'h5);
        xfer(1'b1, 10'h001, 32'h1122_3344, 4'ha);
        xfer(1'b0, 10'h001, 32'h0, 4'h0);
        check(got, 32'h11bb_33dd);
        // status, beyond-map and top-of-window accesses all fail
        for (int i = 0; i < 4; i++)
        begin
            xfer(bad_wr[i], bad_idx[i], 32'hdead_beef, bad_wr[i] ? 4'hf : 4'h0);
            check({31'h0, got_err}, 32'h1);
            if (!bad_wr[i])
                check(got, 32'h0);
        end
        xfer(1'b0, 10'h000, 32'h0, 4'h0);
        check(got, 32'h5a00_0000);
        override = 1'b1;
        repeat (8) @(negedge clk_sys);
        check({31'h0, gate_open}, 32'h1);
        // status: ten landed writes, four refusals, override and gate both set
        xfer(1'b0, STATUS_IDX, 32'h0, 4'h0);
        check(got, 32'h000a_0403);
        check({31'h0, got_err}, 32'h0);
        override = 1'b0;
        repeat (8) @(negedge clk_sys);
        check({31'h0, gate_open}, 32'h0);
        // second reset in mid-run must clear at once
        rst = 1'b1;
        #1;
        check(control_word, REG_RESET);
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        repeat (6) @(negedge clk_sys);
        xfer(1'b0, 10'h003, 32'h0, 4'h0);
        check(got, REG_RESET);
        conclude();
    end

endmodule : testbench

`default_nettype wire
